/* File: common/iex_defs.vh */
// constants for the instruction execution subset: offsets, fields, resets, encodings
//
// Contract
// - sleep resets the watchdog counter to zero and clears its prescaler.
// - sleep sets the timeout flag and leaves the pin change wake flag as it was.
// - sleep clears the powerdown flag.
// - after sleep the core enters low power and stops its oscillator.
// - rotate left moves file f one bit left through carry into w (d=0) or f (d=1), only carry changes.
// - subtract forms f minus w in two's complement into w or f and updates carry, digit carry and zero.
// - rotate right moves file f one bit right through carry into w or f, only carry changes.
// - nibble exchange puts f bits 3:0 into dest bits 7:4 and bits 7:4 into 3:0, no flag changes.
// - direction load copies w into the port direction register when operand f is 6, no flag changes.
// - literal xor combines w with an eight bit literal and leaves the result in w.
// - file xor combines w with file f into w or f and updates zero.
`ifndef IEX_DEFS_VH
`define IEX_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// register byte addresses
`define IEX_ADDR_CMD       8'h00
`define IEX_ADDR_WORK      8'h04
`define IEX_ADDR_STATUS    8'h08
`define IEX_ADDR_DIR       8'h0C
`define IEX_ADDR_WDT       8'h10
`define IEX_ADDR_FILE_BASE 8'h80

////////////////////////////////////////////////////////////////////////////////
// command word fields
`define IEX_CMD_OP_HI  3
`define IEX_CMD_OP_LO  0
`define IEX_CMD_D_BIT  4
`define IEX_CMD_F_HI   12
`define IEX_CMD_F_LO   8
`define IEX_CMD_K_HI   23
`define IEX_CMD_K_LO   16

// operation codes
`define IEX_OP_SLEEP  4'h0
`define IEX_OP_ROTL   4'h1
`define IEX_OP_SUB    4'h2
`define IEX_OP_ROTR   4'h3
`define IEX_OP_SWAP   4'h4
`define IEX_OP_DIR    4'h5
`define IEX_OP_XORL   4'h6
`define IEX_OP_XORF   4'h7

// operand that selects the port direction register
`define IEX_DIR_FILE  5'h06

////////////////////////////////////////////////////////////////////////////////
// status bit positions
`define IEX_ST_CARRY   0
`define IEX_ST_DIGIT   1
`define IEX_ST_ZERO    2
`define IEX_ST_PWRDN   3
`define IEX_ST_TMOUT   4
`define IEX_ST_SLEEP   5
`define IEX_ST_WAKE    7

////////////////////////////////////////////////////////////////////////////////
// reset values
`define IEX_RST_WORK   8'h00
`define IEX_RST_FILE   8'h00
`define IEX_RST_DIR    8'hFF
`define IEX_RST_FLAG_C 1'b0
`define IEX_RST_TMOUT  1'b1
`define IEX_RST_PWRDN  1'b1
`define IEX_WDT_CLEAR  8'h00

`endif

/* File: design/iex_alu.v */
// combinational operand path for the supported instructions
`timescale 1ns/1ps
`include "iex_defs.vh"

module iex_alu (
    input  wire [3:0] op_in,
    input  wire [7:0] file_in,
    input  wire [7:0] work_in,
    input  wire [7:0] lit_in,
    input  wire       carry_in,
    output reg  [7:0] result_out,
    output reg        carry_out,
    output reg        digit_out,
    output reg        zero_out,
    output reg        upd_carry_out,
    output reg        upd_digit_out,
    output reg        upd_zero_out
);

    reg [8:0] diff;
    reg [4:0] ndiff;

    ////////////////////////////////////////////////////////////////////////////
    // result and flag selection per operation
    always @*
    begin
        diff          = {1'b0, file_in} - {1'b0, work_in};
        ndiff         = {1'b0, file_in[3:0]} - {1'b0, work_in[3:0]};
        result_out    = 8'h00;
        carry_out     = carry_in;
        digit_out     = 1'b0;
        upd_carry_out = 1'b0;
        upd_digit_out = 1'b0;
        upd_zero_out  = 1'b0;
        case (op_in)
            `IEX_OP_ROTL:
            begin
                result_out    = {file_in[6:0], carry_in};
                carry_out     = file_in[7];
                upd_carry_out = 1'b1;
            end
            `IEX_OP_ROTR:
            begin
                result_out    = {carry_in, file_in[7:1]};
                carry_out     = file_in[0];
                upd_carry_out = 1'b1;
            end
            `IEX_OP_SUB:
            begin
                // carry is the inverted borrow, as in two's complement add
                result_out    = diff[7:0];
                carry_out     = ~diff[8];
                digit_out     = ~ndiff[4];
                upd_carry_out = 1'b1;
                upd_digit_out = 1'b1;
                upd_zero_out  = 1'b1;
            end
            `IEX_OP_SWAP:
                result_out = {file_in[3:0], file_in[7:4]};
            `IEX_OP_DIR:
                result_out = work_in;
            `IEX_OP_XORL:
            begin
                result_out   = work_in ^ lit_in;
                upd_zero_out = 1'b1;
            end
            `IEX_OP_XORF:
            begin
                result_out   = work_in ^ file_in;
                upd_zero_out = 1'b1;
            end
            default:
                result_out = 8'h00;
        endcase
        zero_out = (result_out == 8'h00);
    end

endmodule

/* File: design/iex_exec.v */
// instruction execution subset with an avalon-mm register slave
`timescale 1ns/1ps
`include "iex_defs.vh"

module iex_exec (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire [7:0]  address_in,
    input  wire        read_in,
    input  wire        write_in,
    input  wire [31:0] writedata_in,
    input  wire [3:0]  byteenable_in,
    input  wire        wake_in,
    output reg  [31:0] readdata_out,
    output reg         waitrequest_out,
    output reg         sleep_out,
    output reg         osc_stop_out,
    output reg  [7:0]  port_dir_out
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    reg  [7:0] work_reg;
    reg  [7:0] file_reg [0:31];
    reg        carry_reg;
    reg        digit_carry_flag_reg;
    reg        zero_reg;
    reg        timeout_flag_reg;
    reg        powerdown_flag_reg;
    reg        pin_change_wake_flag_reg;

    wire [3:0] cmd_op;
    wire       cmd_d;
    wire [4:0] cmd_f;
    wire [7:0] cmd_k;
    wire [7:0] alu_result;
    wire       alu_carry;
    wire       alu_digit;
    wire       alu_zero;
    wire       alu_upd_c;
    wire       alu_upd_digit;
    wire       alu_upd_z;
    wire [7:0] wdt_count;
    wire [7:0] wdt_prescale;
    wire       bus_write;
    wire       bus_start;
    wire       file_sel;
    wire [4:0] file_idx;
    wire       cmd_go;
    wire       do_sleep;
    wire       dest_file;
    wire       dest_work;
    wire [7:0] status_word;
    wire       cmd_lanes_ok;

    // instruction decode
    wire       op_sleep;
    wire       op_rotl;
    wire       op_rotr;
    wire       op_sub;
    wire       op_swap;
    wire       op_dir;
    wire       op_xorl;
    wire       op_xorf;
    wire       op_to_dest;
    wire       dir_load;

    // software write strobes and read path
    wire       reg_wr_ok;
    wire       work_wr;
    wire       status_wr;
    wire       file_wr;
    reg [31:0] read_value;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: a write lands on the edge where waitrequest is seen low
    assign bus_start = (read_in | write_in) & waitrequest_out;
    assign bus_write = write_in & ~waitrequest_out;
    assign file_sel  = address_in[7];
    assign file_idx  = address_in[6:2];

    // software writes to the 8-bit registers need the low byte lane
    assign reg_wr_ok = bus_write & byteenable_in[0];
    assign work_wr   = reg_wr_ok & (address_in == `IEX_ADDR_WORK);
    assign status_wr = reg_wr_ok & (address_in == `IEX_ADDR_STATUS);
    assign file_wr   = reg_wr_ok & file_sel;

    // a command needs the op, operand and literal lanes together; a partial
    // write would run an op with a stale literal or operand, so it is dropped
    assign cmd_lanes_ok = &byteenable_in[2:0];
    assign cmd_go       = bus_write & (address_in == `IEX_ADDR_CMD)
                        & cmd_lanes_ok & ~sleep_out; // commands ignored in sleep

    assign cmd_op = writedata_in[`IEX_CMD_OP_HI:`IEX_CMD_OP_LO];
    assign cmd_d  = writedata_in[`IEX_CMD_D_BIT];
    assign cmd_f  = writedata_in[`IEX_CMD_F_HI:`IEX_CMD_F_LO];
    assign cmd_k  = writedata_in[`IEX_CMD_K_HI:`IEX_CMD_K_LO];

    // codes 8 to 15 match nothing here and run as no-ops
    assign op_sleep = (cmd_op == `IEX_OP_SLEEP);
    assign op_rotl  = (cmd_op == `IEX_OP_ROTL);
    assign op_rotr  = (cmd_op == `IEX_OP_ROTR);
    assign op_sub   = (cmd_op == `IEX_OP_SUB);
    assign op_swap  = (cmd_op == `IEX_OP_SWAP);
    assign op_dir   = (cmd_op == `IEX_OP_DIR);
    assign op_xorl  = (cmd_op == `IEX_OP_XORL);
    assign op_xorf  = (cmd_op == `IEX_OP_XORF);

    assign do_sleep = cmd_go & op_sleep;
    // any other operand is dropped so a stray load cannot flip port pins
    assign dir_load = cmd_go & op_dir & (cmd_f == `IEX_DIR_FILE);

    ////////////////////////////////////////////////////////////////////////////
    // destination select from the d bit
    // ops that carry a d bit; the literal xor always lands in w
    assign op_to_dest = op_rotl | op_rotr | op_sub | op_swap | op_xorf;
    assign dest_file  = cmd_go & cmd_d & op_to_dest;
    assign dest_work  = cmd_go & ((~cmd_d & op_to_dest) | op_xorl);

    assign status_word = {pin_change_wake_flag_reg, 1'b0, sleep_out, timeout_flag_reg,
                          powerdown_flag_reg, zero_reg, digit_carry_flag_reg, carry_reg};

    ////////////////////////////////////////////////////////////////////////////
    // operand path and watchdog
    iex_alu u_alu (
        .op_in         (cmd_op),
        .file_in       (file_reg[cmd_f]),
        .work_in       (work_reg),
        .lit_in        (cmd_k),
        .carry_in      (carry_reg),
        .result_out    (alu_result),
        .carry_out     (alu_carry),
        .digit_out     (alu_digit),
        .zero_out      (alu_zero),
        .upd_carry_out (alu_upd_c),
        .upd_digit_out (alu_upd_digit),
        .upd_zero_out  (alu_upd_z)
    );

    // sleep clears both stages in one edge so the wake timing restarts cleanly
    iex_wdt u_wdt (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .clear_in     (do_sleep),
        .count_out    (wdt_count),
        .prescale_out (wdt_prescale)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read value; the command word and unmapped addresses read as zero
    always @*
    begin
        read_value = 32'h0000_0000;
        if (file_sel)
            read_value = {24'h00_0000, file_reg[file_idx]};
        else
            case (address_in)
                `IEX_ADDR_WORK:   read_value = {24'h00_0000, work_reg};
                `IEX_ADDR_STATUS: read_value = {24'h00_0000, status_word};
                `IEX_ADDR_DIR:    read_value = {24'h00_0000, port_dir_out};
                `IEX_ADDR_WDT:    read_value = {16'h0000, wdt_prescale, wdt_count};
                default:          read_value = 32'h0000_0000;
            endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon handshake: one wait cycle, read data captured with the ack
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            waitrequest_out <= 1'b1;
            readdata_out    <= 32'h0000_0000;
        end
        else if (bus_start)
        begin
            waitrequest_out <= 1'b0;
            if (read_in)
                readdata_out <= read_value;
            else
                readdata_out <= 32'h0000_0000; // a write ack carries no data
        end
        else
            waitrequest_out <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // working register: instruction result or software write
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            work_reg <= `IEX_RST_WORK;
        else if (dest_work)
            work_reg <= alu_result;
        else if (work_wr)
            work_reg <= writedata_in[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // file registers: instruction write-back or direct software access
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1)
        begin : g_file
            always @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                    file_reg[gi] <= `IEX_RST_FILE;
                else if (dest_file & (cmd_f == gi))
                    file_reg[gi] <= alu_result;
                else if (file_wr & (file_idx == gi))
                    file_reg[gi] <= writedata_in[7:0];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // port direction register, loaded only for the one legal operand
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            port_dir_out <= `IEX_RST_DIR;
        else if (dir_load)
            port_dir_out <= alu_result;
    end

    ////////////////////////////////////////////////////////////////////////////
    // arithmetic flags: instructions touch only the flags they own
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            carry_reg <= `IEX_RST_FLAG_C;
            digit_carry_flag_reg <= `IEX_RST_FLAG_C;
            zero_reg  <= `IEX_RST_FLAG_C;
        end
        else if (cmd_go)
        begin
            if (alu_upd_c)
                carry_reg <= alu_carry;
            if (alu_upd_digit)
                digit_carry_flag_reg <= alu_digit;
            if (alu_upd_z)
                zero_reg <= alu_zero;
        end
        else if (status_wr)
        begin
            carry_reg <= writedata_in[`IEX_ST_CARRY];
            digit_carry_flag_reg <= writedata_in[`IEX_ST_DIGIT];
            zero_reg  <= writedata_in[`IEX_ST_ZERO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power status flags; sleep wins over a status write on the same edge
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            timeout_flag_reg   <= `IEX_RST_TMOUT;
            powerdown_flag_reg <= `IEX_RST_PWRDN;
        end
        else if (do_sleep)
        begin
            timeout_flag_reg   <= 1'b1;
            powerdown_flag_reg <= 1'b0;
        end
        else if (status_wr)
        begin
            timeout_flag_reg   <= writedata_in[`IEX_ST_TMOUT];
            powerdown_flag_reg <= writedata_in[`IEX_ST_PWRDN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake flag: sleep leaves it alone, a wake while asleep sets it, set beats a clear
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            pin_change_wake_flag_reg <= 1'b0;
        else if (wake_in & sleep_out)
            pin_change_wake_flag_reg <= 1'b1;
        else if (status_wr & ~do_sleep)
            pin_change_wake_flag_reg <= writedata_in[`IEX_ST_WAKE];
    end

    ////////////////////////////////////////////////////////////////////////////
    // low power state; the bus stays alive so software can observe it
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sleep_out    <= 1'b0;
            osc_stop_out <= 1'b0;
        end
        else if (do_sleep)
        begin
            sleep_out    <= 1'b1;
            osc_stop_out <= 1'b1;
        end
        else if (wake_in)
        begin
            sleep_out    <= 1'b0;
            osc_stop_out <= 1'b0;
        end
    end

endmodule

/* File: design/iex_wdt.v */
// watchdog prescaler and counter with synchronous clear
`timescale 1ns/1ps
`include "iex_defs.vh"

module iex_wdt (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       clear_in,
    output reg  [7:0] count_out,
    output reg  [7:0] prescale_out
);

    ////////////////////////////////////////////////////////////////////////////
    // free running; the counter steps each time the prescaler wraps
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count_out    <= `IEX_WDT_CLEAR;
            prescale_out <= `IEX_WDT_CLEAR;
        end
        else if (clear_in)
        begin
            count_out    <= `IEX_WDT_CLEAR;
            prescale_out <= `IEX_WDT_CLEAR;
        end
        else
        begin
            prescale_out <= prescale_out + 8'h01;
            if (prescale_out == 8'hFF)
                count_out <= count_out + 8'h01;
        end
    end

endmodule

/* File: verif/iex_exec_asserts.sv */
// port level checks for the instruction execution subset
`timescale 1ns/1ps
`include "iex_defs.vh"
module iex_exec_asserts (
    input wire        clk_in,
    input wire        rst_in,
    input wire [7:0]  address_in,
    input wire        read_in,
    input wire        write_in,
    input wire [31:0] writedata_in,
    input wire [3:0]  byteenable_in,
    input wire        wake_in,
    input wire [31:0] readdata_out,
    input wire        waitrequest_out,
    input wire        sleep_out,
    input wire        osc_stop_out,
    input wire [7:0]  port_dir_out
);
////////////////////////////////////////////////////////////////////////////////
// decode of a command write at its effective edge
wire       cmd_acc   = write_in && !waitrequest_out && (address_in == `IEX_ADDR_CMD)
                       && (byteenable_in[2:0] == 3'b111);
wire [3:0] cmd_op    = writedata_in[`IEX_CMD_OP_HI:`IEX_CMD_OP_LO];
wire [4:0] cmd_f     = writedata_in[`IEX_CMD_F_HI:`IEX_CMD_F_LO];
wire       sleep_acc = cmd_acc && (cmd_op == `IEX_OP_SLEEP);
wire       dir_acc   = cmd_acc && (cmd_op == `IEX_OP_DIR) && (cmd_f == `IEX_DIR_FILE);
wire       dir_bad   = cmd_acc && (cmd_op == `IEX_OP_DIR) && (cmd_f != `IEX_DIR_FILE);

default clocking cb @(posedge clk_in); endclocking
default disable iff (rst_in);

////////////////////////////////////////////////////////////////////////////////
// bus handshake: one wait cycle, then one ready cycle
a_wait_answer: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
    else $error("request not answered in one cycle");
a_wait_single: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("waitrequest low for more than one cycle");
// sleep entry, hold and exit
a_osc_tracks: assert property (osc_stop_out == sleep_out)
    else $error("oscillator stop differs from sleep");
a_sleep_entry: assert property (sleep_acc && !sleep_out |=> sleep_out && osc_stop_out)
    else $error("sleep command did not stop the core");
a_sleep_cause: assert property ($rose(sleep_out) |-> $past(sleep_acc))
    else $error("sleep entered without a sleep command");
a_sleep_holds: assert property (sleep_out && !wake_in |=> sleep_out)
    else $error("sleep left without wake");
a_wake_exit: assert property (sleep_out && wake_in |=> !sleep_out)
    else $error("wake did not end sleep");
// direction register changes only through a load of operand 6
a_dir_cause: assert property ($changed(port_dir_out) |-> $past(dir_acc))
    else $error("direction register changed without a load");
a_dir_refused: assert property (dir_bad |=> $stable(port_dir_out))
    else $error("direction load with wrong operand took effect");

c_sleep: cover property (sleep_acc && !sleep_out);
c_dir:   cover property (dir_acc && !sleep_out);
c_wake:  cover property (sleep_out && wake_in);
endmodule

bind iex_exec iex_exec_asserts u_iex_exec_asserts (
    .clk_in(clk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .wake_in(wake_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .sleep_out(sleep_out), .osc_stop_out(osc_stop_out), .port_dir_out(port_dir_out));

/* File: verif/tb.sv */
// self-checking bench for the instruction execution subset
`timescale 1ns/1ps
`include "iex_defs.vh"
module tb;
reg         clk_in;
reg         rst_in;
reg         read_in;
reg         write_in;
reg         wake_in;
reg  [7:0]  address_in;
reg  [31:0] writedata_in;
reg  [3:0]  byteenable_in;
wire [31:0] readdata_out;
wire        waitrequest_out;
wire        sleep_out;
wire        osc_stop_out;
wire [7:0]  port_dir_out;
integer     err_count;
integer     samples_checked;
reg  [31:0] rdat;

iex_exec u_iex_exec (
    .clk_in(clk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .wake_in(wake_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .sleep_out(sleep_out), .osc_stop_out(osc_stop_out), .port_dir_out(port_dir_out));

initial
begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
end

////////////////////////////////////////////////////////////////////////////////
// reporting
task end_of_test;
begin
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
end
endtask

task chk(input string nm, input [31:0] e, input [31:0] g);
begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
        err_count = err_count + 1;
        $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
end
endtask

////////////////////////////////////////////////////////////////////////////////
// one avalon transfer; an idle edge after release avoids double drives
task bus(input w, input [7:0] a, input [31:0] d, input [3:0] be);
    integer n;
begin
    n = 0;
    address_in <= a;
    writedata_in <= d;
    byteenable_in <= be;
    write_in <= w;
    read_in <= !w;
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0)
    begin
        if (n == 40)
        begin
            chk("waitrequest", 0, 1);
            end_of_test;
        end
        n = n + 1;
        @(posedge clk_in);
    end
    rdat = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge clk_in);
end
endtask

task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d, 4'hF);
endtask

task ck(input string nm, input [7:0] a, input [31:0] e);
begin
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(nm, e, rdat);
end
endtask

task ex(input [3:0] op, input dd, input [4:0] f, input [7:0] k);
    wr(`IEX_ADDR_CMD, {8'h00, k, 3'b000, f, 3'b000, dd, op});
endtask

function [7:0] fa(input [4:0] f);
    fa = `IEX_ADDR_FILE_BASE + {1'b0, f, 2'b00};
endfunction

////////////////////////////////////////////////////////////////////////////////
// scenarios
task t_reset;
begin
    ck("status", `IEX_ADDR_STATUS, 8'h18);
    ck("work", `IEX_ADDR_WORK, 8'h00);
    chk("port dir", 8'hFF, port_dir_out);
    ck("unmapped", 8'h40, 8'h00);
    bus(1'b1, `IEX_ADDR_WORK, 32'h0000_00AA, 4'hE);
    ck("work masked", `IEX_ADDR_WORK, 8'h00);
    $display("test reset done");
end
endtask

// rotate codes are 1 (left) and 3 (right)
task t_rotate;
begin
    wr(fa(3), 8'h81);
    wr(`IEX_ADDR_STATUS, 8'h1C);
    ex(4'h1, 1'b1, 5'd3, 8'h00);
    ck("left file", fa(3), 8'h02);
    ck("left status", `IEX_ADDR_STATUS, 8'h1D);
    wr(`IEX_ADDR_WORK, 8'h33);
    ex(4'h3, 1'b0, 5'd3, 8'h00);
    ck("right work", `IEX_ADDR_WORK, 8'h81);
    ck("right file", fa(3), 8'h02);
    ck("right status", `IEX_ADDR_STATUS, 8'h1C);
    $display("test rotate done");
end
endtask

// flags worked out here: carry is no borrow, digit carry no low nibble borrow
task sub_case(input [7:0] f, input [7:0] w, input dd);
    reg [7:0] res;
begin
    res = f - w;
    wr(fa(9), f);
    wr(`IEX_ADDR_WORK, w);
    wr(`IEX_ADDR_STATUS, 8'h18);
    ex(`IEX_OP_SUB, dd, 5'd9, 8'h00);
    ck("sub dest", dd ? fa(9) : `IEX_ADDR_WORK, res);
    ck("sub other", dd ? `IEX_ADDR_WORK : fa(9), dd ? w : f);
    ck("sub status", `IEX_ADDR_STATUS,
       {5'b00011, res == 8'h00, f[3:0] >= w[3:0], f >= w});
end
endtask

task t_subtract;
begin
    sub_case(8'h10, 8'h01, 1'b0);
    sub_case(8'h10, 8'h10, 1'b1);
    sub_case(8'h00, 8'h20, 1'b1);
    $display("test subtract done");
end
endtask

task t_logic;
begin
    wr(fa(7), 8'hA5);
    wr(`IEX_ADDR_STATUS, 8'h1F);
    ex(`IEX_OP_SWAP, 1'b0, 5'd7, 8'h00);
    ck("swap work", `IEX_ADDR_WORK, 8'h5A);
    ck("swap status", `IEX_ADDR_STATUS, 8'h1F);
    ex(`IEX_OP_DIR, 1'b0, 5'd7, 8'h00);
    chk("dir refused", 8'hFF, port_dir_out);
    ex(`IEX_OP_DIR, 1'b0, 5'd6, 8'h00);
    chk("dir load", 8'h5A, port_dir_out);
    ck("dir status", `IEX_ADDR_STATUS, 8'h1F);
    wr(`IEX_ADDR_STATUS, 8'h18);
    ex(`IEX_OP_XORL, 1'b0, 5'd0, 8'h5A);
    ck("xorl work", `IEX_ADDR_WORK, 8'h00);
    ck("xorl status", `IEX_ADDR_STATUS, 8'h1C);
    bus(1'b1, `IEX_ADDR_CMD, {8'h00, 8'hFF, 12'h000, `IEX_OP_XORL}, 4'h3);
    ck("xorl lanes", `IEX_ADDR_WORK, 8'h00);
    wr(`IEX_ADDR_WORK, 8'h0F);
    ex(`IEX_OP_XORF, 1'b1, 5'd7, 8'h00);
    ck("xorf file", fa(7), 8'hAA);
    ck("xorf work", `IEX_ADDR_WORK, 8'h0F);
    ck("xorf status", `IEX_ADDR_STATUS, 8'h18);
    $display("test logic done");
end
endtask

// long idle first so the watchdog holds a nonzero count
task t_sleep;
begin
    repeat (300) @(posedge clk_in);
    wr(`IEX_ADDR_STATUS, 8'h8F);
    ex(`IEX_OP_SLEEP, 1'b0, 5'd0, 8'h00);
    chk("sleep", 1'b1, sleep_out);
    chk("osc stop", 1'b1, osc_stop_out);
    bus(1'b0, `IEX_ADDR_WDT, 32'h0000_0000, 4'hF);
    chk("wdt count", 8'h00, rdat[7:0]);
    chk("wdt prescale low", 1'b1, rdat[15:8] < 8'h10);
    ck("sleep status", `IEX_ADDR_STATUS, 8'hB7);
    ex(`IEX_OP_XORL, 1'b0, 5'd0, 8'hFF);
    ck("work asleep", `IEX_ADDR_WORK, 8'h0F);
    wr(`IEX_ADDR_STATUS, 8'h17);
    ck("wake cleared", `IEX_ADDR_STATUS, 8'h37);
    wake_in <= 1'b1;
    @(posedge clk_in);
    wake_in <= 1'b0;
    @(posedge clk_in);
    chk("awake", 1'b0, sleep_out);
    ck("wake status", `IEX_ADDR_STATUS, 8'h97);
    $display("test sleep done");
end
endtask

initial
begin
    err_count = 0;
    samples_checked = 0;
    rst_in = 1'b1;
    read_in = 1'b0;
    write_in = 1'b0;
    wake_in = 1'b0;
    address_in = 8'h00;
    writedata_in = 32'h0000_0000;
    byteenable_in = 4'h0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset;
    t_rotate;
    t_subtract;
    t_logic;
    t_sleep;
    end_of_test;
end
endmodule
